/* asce_pkg.sv */
// Package for the analyzer set-command executor
package asce_pkg;
  localparam logic [3:0] ASCE_CMD_SET = 4'h7;
  localparam logic [3:0] ASCE_SUB_REG = 4'h0;
  localparam logic [3:0] ASCE_SUB_LINE = 4'h1;
  localparam logic [3:0] ASCE_SUB_TIMER = 4'h2;
  localparam logic [3:0] ASCE_SUB_COUNTER = 4'h3;
  localparam logic [3:0] ASCE_SUB_BUZZ = 4'h4;
  localparam logic [3:0] ASCE_SUB_TRIG = 4'h5;
  // Operand selectors
  localparam logic [2:0] ASCE_OP_CONST = 3'h0;
  localparam logic [2:0] ASCE_OP_A = 3'h1;
  localparam logic [2:0] ASCE_OP_B = 3'h2;
  localparam logic [2:0] ASCE_OP_C = 3'h3;
  localparam logic [2:0] ASCE_OP_D = 3'h4;
  // Special value selectors
  localparam logic [2:0] ASCE_SP_WAIT = 3'h0;
  localparam logic [2:0] ASCE_SP_KEY = 3'h1;
  localparam logic [2:0] ASCE_SP_COUNT = 3'h2;
  localparam logic [2:0] ASCE_SP_BYTE = 3'h3;
  localparam logic [2:0] ASCE_SP_STATION = 3'h4;
  localparam logic [2:0] ASCE_SP_NS = 3'h5;
  localparam logic [2:0] ASCE_SP_NR = 3'h6;
  localparam logic [2:0] ASCE_SP_PF = 3'h7;
  // Line selectors
  localparam logic [2:0] ASCE_LN_RTS = 3'h0;
  localparam logic [2:0] ASCE_LN_CTS = 3'h1;
  localparam logic [2:0] ASCE_LN_DSR = 3'h2;
  localparam logic [2:0] ASCE_LN_DCD = 3'h3;
  localparam logic [2:0] ASCE_LN_DTR = 3'h4;
  localparam logic [2:0] ASCE_LN_RI = 3'h5;
  localparam int ASCE_LN_N = 6;
  localparam int ASCE_VW = 20;
  localparam int ASCE_NVAR = 16;
  localparam int ASCE_NTC = 4;
  // Timing
  localparam int ASCE_CLK_HZ = 40000000;
  localparam int ASCE_TRIG_US = 1000;
  localparam int ASCE_BEEP_US = 100000;
  localparam int ASCE_TRIG_CYC = ASCE_CLK_HZ / 1000000 * ASCE_TRIG_US;
  localparam int ASCE_BEEP_CYC = ASCE_CLK_HZ / 1000000 * ASCE_BEEP_US;
  localparam logic [ASCE_VW-1:0] ASCE_ZERO = 20'h00000;
  localparam logic [ASCE_VW-1:0] ASCE_ONE = 20'h00001;
  // Register map, word addresses times four
  localparam logic [7:0] ASCE_A_CMD = 8'h00;
  localparam logic [7:0] ASCE_A_OPND = 8'h04;
  localparam logic [7:0] ASCE_A_STAT = 8'h08;
  localparam logic [7:0] ASCE_A_CFG = 8'h0c;
  localparam logic [7:0] ASCE_A_VAR = 8'h40;
  localparam logic [7:0] ASCE_A_TPRE = 8'h80;
  localparam logic [7:0] ASCE_A_TVAL = 8'h90;
  localparam logic [7:0] ASCE_A_CVAL = 8'ha0;
  localparam logic [31:0] ASCE_RD_NONE = 32'hdeadbeef;
  typedef enum logic [1:0] {ASCE_IDLE, ASCE_EXEC, ASCE_DONE} asce_state_t;
endpackage

/* asce_top.sv */
// Set-command executor: variables, lines, timers, counters, buzzer, trigger
//
// Decided for this implementation: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module asce_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic prog_start,
  input wire logic dce_role,
  input wire logic auto_line_en,
  input wire logic [asce_pkg::ASCE_LN_N-1:0] auto_line_val,
  input wire logic timer_tick,
  input wire logic [asce_pkg::ASCE_VW-1:0] setup_timer_preset,
  input wire logic [asce_pkg::ASCE_VW-1:0] setup_counter_init,
  input wire logic [3:0] releasing_wait_index,
  input wire logic [3:0] pressed_key_value,
  input wire logic [asce_pkg::ASCE_VW-1:0] captured_byte_count,
  input wire logic [asce_pkg::ASCE_VW-1:0] frame_byte_pointer,
  input wire logic [7:0] frame_byte_at_pointer,
  input wire logic [7:0] station_field,
  input wire logic [6:0] send_sequence_field,
  input wire logic [6:0] receive_sequence_field,
  input wire logic poll_final_bit,
  output logic [asce_pkg::ASCE_LN_N-1:0] line_level,
  output logic [asce_pkg::ASCE_NTC-1:0] timer_running,
  output logic buzzer_on,
  output logic trigger_out_n
);
  import asce_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Command registers and bus slave
  logic [3:0] cmd_q;
  logic [3:0] sub_q;
  logic [2:0] opsel_q;
  logic [3:0] idx_q;
  logic [3:0] src_q;
  logic [ASCE_VW-1:0] const_q;
  asce_state_t state_q;
  logic [ASCE_VW-1:0] var_q [ASCE_NVAR];
  logic [ASCE_VW-1:0] tpre_q [ASCE_NTC];
  logic [ASCE_VW-1:0] tval_q [ASCE_NTC];
  logic [ASCE_VW-1:0] cval_q [ASCE_NTC];
  logic [ASCE_LN_N-1:0] line_q;
  logic [ASCE_NTC-1:0] trun_q;
  logic [31:0] beep_cnt_q;
  logic [31:0] trig_cnt_q;
  logic busy_w;
  logic go_w;
  logic rd_wait_q;

  assign busy_w = (state_q != ASCE_IDLE);
  // Writing the command word launches it; stall while one runs
  assign go_w = write && (address == ASCE_A_CMD) && !busy_w;
  // A command write waits out the previous one
  // Reads take one wait state so the registered data stands when accepted
  assign waitrequest = (write && (address == ASCE_A_CMD) && busy_w) ||
                       (read && !rd_wait_q);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rd_wait_q <= 1'b0;
    end else begin
      rd_wait_q <= read && !rd_wait_q;
    end
  end

  function automatic logic [ASCE_VW-1:0] asce_sel(input logic [ASCE_VW-1:0] a [ASCE_NTC],
                                                  input logic [1:0] i);
    asce_sel = a[i];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cmd_q <= 4'h0;
      sub_q <= 4'h0;
      opsel_q <= ASCE_OP_CONST;
      idx_q <= 4'h0;
      src_q <= 4'h0;
      const_q <= ASCE_ZERO;
    end else begin
      if (write && address == ASCE_A_OPND) begin
        const_q <= writedata[ASCE_VW-1:0];
      end
      if (go_w) begin
        cmd_q <= writedata[15:12];
        sub_q <= writedata[11:8];
        opsel_q <= writedata[7:5];
        idx_q <= writedata[3:0];
        src_q <= writedata[19:16];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ASCE_IDLE;
    end else begin
      unique case (state_q)
        ASCE_IDLE: if (go_w) state_q <= ASCE_EXEC;
        ASCE_EXEC: state_q <= ASCE_DONE;
        ASCE_DONE: state_q <= ASCE_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      readdata <= 32'h0;
    end else if (read && !rd_wait_q) begin
      if (address == ASCE_A_STAT) begin
        readdata <= {22'h0, trig_cnt_q != 32'h0, beep_cnt_q != 32'h0, line_q, busy_w, 1'b0};
      end else if (address == ASCE_A_OPND) begin
        readdata <= {12'h0, const_q};
      end else if (address[7:6] == ASCE_A_VAR[7:6]) begin
        readdata <= {12'h0, var_q[address[5:2]]};
      end else if (address[7:4] == ASCE_A_TPRE[7:4]) begin
        readdata <= {12'h0, asce_sel(tpre_q, address[3:2])};
      end else if (address[7:4] == ASCE_A_TVAL[7:4]) begin
        readdata <= {12'h0, asce_sel(tval_q, address[3:2])};
      end else if (address[7:4] == ASCE_A_CVAL[7:4]) begin
        readdata <= {12'h0, asce_sel(cval_q, address[3:2])};
      end else begin
        readdata <= ASCE_RD_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special value mux
  logic [ASCE_VW-1:0] special_w;
  always_comb begin
    special_w = ASCE_ZERO;
    unique case (src_q[2:0])
      ASCE_SP_WAIT: special_w = {16'h0, releasing_wait_index};
      ASCE_SP_KEY: special_w = {16'h0, pressed_key_value};
      ASCE_SP_COUNT: special_w = captured_byte_count;
      ASCE_SP_BYTE: special_w = (frame_byte_pointer > captured_byte_count) ?
                                ASCE_ZERO : {12'h0, frame_byte_at_pointer};
      ASCE_SP_STATION: special_w = {12'h0, station_field};
      ASCE_SP_NS: special_w = {13'h0, send_sequence_field};
      ASCE_SP_NR: special_w = {13'h0, receive_sequence_field};
      ASCE_SP_PF: special_w = {19'h0, poll_final_bit};
    endcase
  end

  logic exec_w;
  assign exec_w = (state_q == ASCE_EXEC) && (cmd_q == ASCE_CMD_SET);

  ////////////////////////////////////////////////////////////////////////////
  // General variables
  always_ff @(posedge ref_clk) begin
    if (reset || prog_start) begin
      for (int i = 0; i < ASCE_NVAR; i++) var_q[i] <= ASCE_ZERO;
    end else if (exec_w && sub_q == ASCE_SUB_REG) begin
      unique case (opsel_q)
        ASCE_OP_CONST: var_q[idx_q] <= const_q;
        ASCE_OP_A: var_q[idx_q] <= var_q[idx_q] + ASCE_ONE;
        ASCE_OP_B: var_q[idx_q] <= var_q[idx_q] - ASCE_ONE;
        ASCE_OP_C: var_q[idx_q] <= var_q[src_q];
        ASCE_OP_D: var_q[idx_q] <= special_w;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control lines; DTE drives RTS DTR, DCE drives CTS DSR DCD RI
  logic [ASCE_LN_N-1:0] role_mask_w;
  logic [ASCE_LN_N-1:0] auto_mask_w;
  assign role_mask_w = dce_role ? 6'b101110 : 6'b010001;
  assign auto_mask_w = 6'b011011;
  always_ff @(posedge ref_clk) begin
    if (reset || prog_start) begin
      line_q <= '0;
    end else if (exec_w && sub_q == ASCE_SUB_LINE && idx_q < 4'(ASCE_LN_N)) begin
      if (role_mask_w[idx_q[2:0]]) line_q[idx_q[2:0]] <= const_q[0];
    end
  end
  // Auto control wins over the command on its four lines
  assign line_level = auto_line_en ?
      ((line_q & ~auto_mask_w) | (auto_line_val & auto_mask_w)) : line_q;

  ////////////////////////////////////////////////////////////////////////////
  // Timers and counters
  always_ff @(posedge ref_clk) begin
    if (reset || prog_start) begin
      for (int i = 0; i < ASCE_NTC; i++) begin
        tpre_q[i] <= setup_timer_preset;
        tval_q[i] <= ASCE_ZERO;
        cval_q[i] <= setup_counter_init;
      end
      trun_q <= '0;
    end else begin
      for (int i = 0; i < ASCE_NTC; i++) begin
        if (trun_q[i] && timer_tick) tval_q[i] <= tval_q[i] + ASCE_ONE;
      end
      if (exec_w && sub_q == ASCE_SUB_TIMER) begin
        unique case (opsel_q)
          ASCE_OP_CONST: tpre_q[idx_q[1:0]] <= const_q;
          ASCE_OP_A: trun_q[idx_q[1:0]] <= 1'b1;
          ASCE_OP_B: trun_q[idx_q[1:0]] <= 1'b0;
          ASCE_OP_C: begin
            tval_q[idx_q[1:0]] <= ASCE_ZERO;
            trun_q[idx_q[1:0]] <= 1'b1;
          end
          default: ;
        endcase
      end
      if (exec_w && sub_q == ASCE_SUB_COUNTER) begin
        unique case (opsel_q)
          ASCE_OP_CONST: cval_q[idx_q[1:0]] <= const_q;
          ASCE_OP_A: cval_q[idx_q[1:0]] <= cval_q[idx_q[1:0]] + ASCE_ONE;
          ASCE_OP_B: cval_q[idx_q[1:0]] <= ASCE_ZERO;
          default: ;
        endcase
      end
    end
  end
  assign timer_running = trun_q;

  ////////////////////////////////////////////////////////////////////////////
  // Buzzer and trigger pulse
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      beep_cnt_q <= 32'h0;
    end else if (exec_w && sub_q == ASCE_SUB_BUZZ) begin
      beep_cnt_q <= 32'(ASCE_BEEP_CYC);
    end else if (beep_cnt_q != 32'h0) begin
      beep_cnt_q <= beep_cnt_q - 32'h1;
    end
  end
  assign buzzer_on = (beep_cnt_q != 32'h0);

  // Retrigger is ignored so the far end never sees a merged edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trig_cnt_q <= 32'h0;
    end else if (exec_w && sub_q == ASCE_SUB_TRIG && trig_cnt_q == 32'h0) begin
      trig_cnt_q <= 32'(ASCE_TRIG_CYC);
    end else if (trig_cnt_q != 32'h0) begin
      trig_cnt_q <= trig_cnt_q - 32'h1;
    end
  end
  assign trigger_out_n = (trig_cnt_q == 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence cmd_exec_s(logic [3:0] s);
    exec_w && sub_q == s;
  endsequence

  var_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
    prog_start |=> var_q[0] == ASCE_ZERO && var_q[15] == ASCE_ZERO)
    else $error("variables not cleared at start");
  var_inc_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_REG) && opsel_q == ASCE_OP_A
    |=> var_q[$past(idx_q)] == $past(var_q[idx_q]) + ASCE_ONE)
    else $error("increment wrong");
  var_const_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_REG) && opsel_q == ASCE_OP_CONST |=> var_q[$past(idx_q)] == $past(const_q))
    else $error("constant load wrong");
  byte_zero_a: assert property (@(posedge ref_clk) disable iff (reset)
    src_q[2:0] == ASCE_SP_BYTE && frame_byte_pointer > captured_byte_count |-> special_w == ASCE_ZERO)
    else $error("byte past count not zero");
  line_mark_a: assert property (@(posedge ref_clk) disable iff (reset)
    prog_start |=> line_q == '0)
    else $error("lines not at mark");
  line_role_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    $changed(line_q) && !$past(prog_start)
    |-> (($past(line_q) ^ line_q) & ~$past(role_mask_w)) == '0)
    else $error("non-output line driven");
  auto_line_a: assert property (@(posedge ref_clk) disable iff (reset)
    auto_line_en |-> (line_level & auto_mask_w) == (auto_line_val & auto_mask_w))
    else $error("auto control not followed");
  timer_restart_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_TIMER) && opsel_q == ASCE_OP_C
    |=> trun_q[$past(idx_q[1:0])] && tval_q[$past(idx_q[1:0])] == ASCE_ZERO)
    else $error("restart wrong");
  cnt_clear_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_COUNTER) && opsel_q == ASCE_OP_B |=> cval_q[$past(idx_q[1:0])] == ASCE_ZERO)
    else $error("counter clear wrong");
  trig_start_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_exec_s(ASCE_SUB_TRIG) && trigger_out_n |=> !trigger_out_n [*8])
    else $error("trigger pulse not started");
  trig_retrig_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_exec_s(ASCE_SUB_TRIG) && !trigger_out_n |=> trig_cnt_q == $past(trig_cnt_q) - 32'h1)
    else $error("pulse restarted");
  one_at_time_a: assert property (@(posedge ref_clk) disable iff (reset)
    go_w |=> state_q == ASCE_EXEC ##1 state_q == ASCE_DONE ##1 state_q == ASCE_IDLE)
    else $error("command sequence wrong");

  // Variable operand paths
  var_dec_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_REG) && opsel_q == ASCE_OP_B
    |=> var_q[$past(idx_q)] == $past(var_q[idx_q]) - ASCE_ONE)
    else $error("decrement wrong");
  var_copy_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_REG) && opsel_q == ASCE_OP_C |=> var_q[$past(idx_q)] == $past(var_q[src_q]))
    else $error("copy wrong");
  var_special_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_REG) && opsel_q == ASCE_OP_D |=> var_q[$past(idx_q)] == $past(special_w))
    else $error("special load wrong");

  // Line drive
  line_drive_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_LINE) && idx_q < 4'(ASCE_LN_N) && role_mask_w[idx_q[2:0]]
    |=> line_q[$past(idx_q[2:0])] == $past(const_q[0]))
    else $error("line level not driven");

  // Timer and counter control
  timer_preset_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_TIMER) && opsel_q == ASCE_OP_CONST
    |=> tpre_q[$past(idx_q[1:0])] == $past(const_q))
    else $error("timer preset wrong");
  timer_start_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_TIMER) && opsel_q == ASCE_OP_A |=> trun_q[$past(idx_q[1:0])])
    else $error("timer not started");
  timer_stop_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_TIMER) && opsel_q == ASCE_OP_B |=> !trun_q[$past(idx_q[1:0])])
    else $error("timer not stopped");
  cnt_load_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_COUNTER) && opsel_q == ASCE_OP_CONST
    |=> cval_q[$past(idx_q[1:0])] == $past(const_q))
    else $error("counter load wrong");
  cnt_inc_a: assert property (@(posedge ref_clk) disable iff (reset || prog_start)
    cmd_exec_s(ASCE_SUB_COUNTER) && opsel_q == ASCE_OP_A
    |=> cval_q[$past(idx_q[1:0])] == $past(cval_q[idx_q[1:0]]) + ASCE_ONE)
    else $error("counter increment wrong");

  // Buzzer and bus handshake
  buzz_on_a: assert property (@(posedge ref_clk) disable iff (reset)
    cmd_exec_s(ASCE_SUB_BUZZ) |=> buzzer_on)
    else $error("buzzer not sounding");
  cmd_stall_a: assert property (@(posedge ref_clk) disable iff (reset)
    write && address == ASCE_A_CMD && busy_w |-> waitrequest && !go_w)
    else $error("command accepted while busy");
  read_wait_a: assert property (@(posedge ref_clk) disable iff (reset)
    read && !rd_wait_q |-> waitrequest)
    else $error("read accepted before data ready");
endmodule // asce_top
`default_nettype wire

/* asce_line_partner.sv */
// Far-side model: frame capture sources and trigger input
`timescale 1ns/1ps
`default_nettype none
module asce_line_partner (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic trigger_out_n,
  output logic [3:0] releasing_wait_index,
  output logic [3:0] pressed_key_value,
  output logic [19:0] captured_byte_count,
  output logic [7:0] frame_byte_at_pointer,
  output logic [7:0] station_field,
  output logic [6:0] send_sequence_field,
  output logic [6:0] receive_sequence_field,
  output logic poll_final_bit,
  output int trig_falls,
  output int trig_low_len
);
  int low_cnt;
  logic trig_q;
  ////////////////////////////////////////////////////////////////////////
  // Last frame captured; held steady so the bench can predict it
  assign releasing_wait_index = 4'h9;
  assign pressed_key_value = 4'hc;
  assign captured_byte_count = 20'h00005;
  assign frame_byte_at_pointer = 8'ha5;
  assign station_field = 8'h3c;
  assign send_sequence_field = 7'h51;
  assign receive_sequence_field = 7'h2a;
  assign poll_final_bit = 1'b1;
  ////////////////////////////////////////////////////////////////////////
  // Trigger input counts falling edges and the low time in cycles
  always @(posedge ref_clk) begin
    if (reset) begin
      trig_falls <= 0;
      low_cnt <= 0;
      trig_low_len <= 0;
    end else begin
      if (trig_q === 1'b1 && trigger_out_n === 1'b0) trig_falls <= trig_falls + 1;
      if (trigger_out_n === 1'b0) low_cnt <= low_cnt + 1;
      if (trig_q === 1'b0 && trigger_out_n === 1'b1) begin
        trig_low_len <= low_cnt;
        low_cnt <= 0;
      end
    end
    trig_q <= trigger_out_n;
  end
endmodule // asce_line_partner
`default_nettype wire

/* analyzer_set_command_executor_test.sv */
// Self-checking bench for the set-command executor
`timescale 1ns/1ps
`default_nettype none
module analyzer_set_command_executor_test;
  import asce_pkg::*;
  logic ref_clk, reset, read, write, prog_start, dce_role, auto_line_en, timer_tick, waitrequest;
  logic buzzer_on, trigger_out_n, poll_final_bit;
  logic [7:0] address, frame_byte_at_pointer, station_field;
  logic [31:0] writedata, readdata, rv;
  logic [5:0] auto_line_val, line_level;
  logic [3:0] timer_running, releasing_wait_index, pressed_key_value;
  logic [19:0] captured_byte_count, frame_byte_pointer;
  logic [6:0] send_sequence_field, receive_sequence_field;
  int error_cnt, cmp_count, trig_falls, trig_low_len, n;
  logic [31:0] sp_exp [8] = '{32'h9, 32'hc, 32'h5, 32'ha5, 32'h3c, 32'h51, 32'h2a, 32'h1};
  ////////////////////////////////////////////////////////////////////////
  asce_top u_dut (.ref_clk(ref_clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .prog_start(prog_start), .dce_role(dce_role), .auto_line_en(auto_line_en),
    .auto_line_val(auto_line_val), .timer_tick(timer_tick),
    .setup_timer_preset(20'h00777), .setup_counter_init(20'h00042),
    .releasing_wait_index(releasing_wait_index), .pressed_key_value(pressed_key_value),
    .captured_byte_count(captured_byte_count), .frame_byte_pointer(frame_byte_pointer),
    .frame_byte_at_pointer(frame_byte_at_pointer), .station_field(station_field),
    .send_sequence_field(send_sequence_field), .receive_sequence_field(receive_sequence_field),
    .poll_final_bit(poll_final_bit), .line_level(line_level), .timer_running(timer_running),
    .buzzer_on(buzzer_on), .trigger_out_n(trigger_out_n));
  asce_line_partner u_far (.ref_clk(ref_clk), .reset(reset), .trigger_out_n(trigger_out_n),
    .releasing_wait_index(releasing_wait_index), .pressed_key_value(pressed_key_value),
    .captured_byte_count(captured_byte_count), .frame_byte_at_pointer(frame_byte_at_pointer),
    .station_field(station_field), .send_sequence_field(send_sequence_field),
    .receive_sequence_field(receive_sequence_field), .poll_final_bit(poll_final_bit),
    .trig_falls(trig_falls), .trig_low_len(trig_low_len));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Waits at the falling edge; inputs only move at rising edges
  task automatic wait_ready();
    int k;
    k = 0;
    do begin @(negedge ref_clk); k++; end while (waitrequest !== 1'b0 && k < 50);
    if (k >= 50) begin error_cnt++; final_report(); end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    wait_ready();
    @(posedge ref_clk);
    write <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Data stands once waitrequest drops; taken before the accepting edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    address <= a;
    read <= 1'b1;
    wait_ready();
    d = readdata;
    @(posedge ref_clk);
    read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic idle();
    int k;
    k = 0;
    do begin rd(ASCE_A_STAT, rv); k++; end while (rv[1] !== 1'b0 && k < 20);
    if (k >= 20) begin error_cnt++; final_report(); end
  endtask
  task automatic cmd(input logic [3:0] sub, input logic [2:0] op, input logic [3:0] idx,
                     input logic [3:0] src, input logic [19:0] v);
    wr(ASCE_A_OPND, {12'h000, v});
    wr(ASCE_A_CMD, {12'h000, src, ASCE_CMD_SET, sub, op, 1'b0, idx});
  endtask
  task automatic rchk(input logic [7:0] base, input logic [3:0] i, input logic [31:0] e);
    idle();
    rd(base + {2'b00, i, 2'b00}, rv);
    chk(rv, e);
  endtask
  task automatic start();
    prog_start <= 1'b1;
    @(posedge ref_clk);
    prog_start <= 1'b0;
    @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset, read, write, prog_start, dce_role, auto_line_en, timer_tick} = 7'h40;
    address = 8'h00;
    writedata = 32'h0;
    auto_line_val = 6'h00;
    frame_byte_pointer = 20'h00003;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    start();
    for (int i = 0; i < 16; i++) rchk(ASCE_A_VAR, i[3:0], 32'h0);
    chk({26'h0, line_level}, 32'h0);
    chk({31'h0, trigger_out_n}, 32'h1);
    rd(8'hfc, rv);
    chk(rv, ASCE_RD_NONE);
    // Variables: load, step, copy, back to back
    cmd(ASCE_SUB_REG, ASCE_OP_CONST, 4'h3, 4'h0, 20'h1e240);
    rchk(ASCE_A_VAR, 4'h3, 32'h1e240);
    cmd(ASCE_SUB_REG, ASCE_OP_A, 4'h3, 4'h0, 20'h0);
    cmd(ASCE_SUB_REG, ASCE_OP_A, 4'h3, 4'h0, 20'h0);
    rchk(ASCE_A_VAR, 4'h3, 32'h1e242);
    cmd(ASCE_SUB_REG, ASCE_OP_B, 4'h3, 4'h0, 20'h0);
    rchk(ASCE_A_VAR, 4'h3, 32'h1e241);
    cmd(ASCE_SUB_REG, ASCE_OP_C, 4'h5, 4'h3, 20'h0);
    rchk(ASCE_A_VAR, 4'h5, 32'h1e241);
    for (int i = 0; i < 8; i++) begin
      cmd(ASCE_SUB_REG, ASCE_OP_D, 4'h8, i[3:0], 20'h0);
      rchk(ASCE_A_VAR, 4'h8, sp_exp[i]);
    end
    frame_byte_pointer <= 20'h00006;
    cmd(ASCE_SUB_REG, ASCE_OP_D, 4'h9, 4'h3, 20'h0);
    rchk(ASCE_A_VAR, 4'h9, 32'h0);
    // Lines: terminal role, then modem role, then automatic control
    for (int i = 0; i < 6; i++) cmd(ASCE_SUB_LINE, 3'h0, i[3:0], 4'h0, 20'h1);
    idle();
    chk({26'h0, line_level}, 32'h11);
    dce_role <= 1'b1;
    start();
    for (int i = 0; i < 6; i++) cmd(ASCE_SUB_LINE, 3'h0, i[3:0], 4'h0, 20'h1);
    idle();
    chk({26'h0, line_level}, 32'h2e);
    auto_line_val <= 6'h11;
    auto_line_en <= 1'b1;
    cmd(ASCE_SUB_LINE, 3'h0, 4'h1, 4'h0, 20'h0);
    cmd(ASCE_SUB_LINE, 3'h0, 4'h2, 4'h0, 20'h0);
    idle();
    chk({26'h0, line_level}, 32'h31);
    // Timers and counters
    rchk(ASCE_A_TPRE, 4'h0, 32'h777);
    rchk(ASCE_A_CVAL, 4'h3, 32'h42);
    cmd(ASCE_SUB_TIMER, ASCE_OP_CONST, 4'h2, 4'h0, 20'h0abcd);
    rchk(ASCE_A_TPRE, 4'h2, 32'habcd);
    cmd(ASCE_SUB_TIMER, ASCE_OP_C, 4'h2, 4'h0, 20'h0);
    idle();
    chk({28'h0, timer_running}, 32'h4);
    repeat (3) begin timer_tick <= 1'b1; @(posedge ref_clk); timer_tick <= 1'b0; @(posedge ref_clk); end
    cmd(ASCE_SUB_TIMER, ASCE_OP_B, 4'h2, 4'h0, 20'h0);
    idle();
    chk({28'h0, timer_running}, 32'h0);
    repeat (2) begin timer_tick <= 1'b1; @(posedge ref_clk); timer_tick <= 1'b0; @(posedge ref_clk); end
    rchk(ASCE_A_TVAL, 4'h2, 32'h3);
    cmd(ASCE_SUB_TIMER, ASCE_OP_A, 4'h2, 4'h0, 20'h0);
    idle();
    timer_tick <= 1'b1;
    @(posedge ref_clk);
    timer_tick <= 1'b0;
    rchk(ASCE_A_TVAL, 4'h2, 32'h4);
    cmd(ASCE_SUB_COUNTER, ASCE_OP_CONST, 4'h1, 4'h0, 20'h99999);
    rchk(ASCE_A_CVAL, 4'h1, 32'h99999);
    cmd(ASCE_SUB_COUNTER, ASCE_OP_A, 4'h1, 4'h0, 20'h0);
    rchk(ASCE_A_CVAL, 4'h1, 32'h9999a);
    cmd(ASCE_SUB_COUNTER, ASCE_OP_B, 4'h1, 4'h0, 20'h0);
    rchk(ASCE_A_CVAL, 4'h1, 32'h0);
    // Buzzer, then trigger with a repeat while the pulse runs
    cmd(ASCE_SUB_BUZZ, 3'h0, 4'h0, 4'h0, 20'h0);
    idle();
    chk({31'h0, buzzer_on}, 32'h1);
    cmd(ASCE_SUB_TRIG, 3'h0, 4'h0, 4'h0, 20'h0);
    idle();
    chk({31'h0, trigger_out_n}, 32'h0);
    repeat (20000) @(posedge ref_clk);
    cmd(ASCE_SUB_TRIG, 3'h0, 4'h0, 4'h0, 20'h0);
    n = 0;
    while (trigger_out_n !== 1'b1 && n < 45000) begin @(posedge ref_clk); n++; end
    if (n >= 45000) begin error_cnt++; final_report(); end
    repeat (2) @(posedge ref_clk);
    chk(trig_low_len, ASCE_TRIG_CYC);
    chk(trig_falls, 32'h1);
    final_report();
  end
endmodule // analyzer_set_command_executor_test
`default_nettype wire
